/* logic/brad_decode.sv */
`timescale 1ns/1ps
// One per-master address decoder; every copy uses the same map
module brad_decode (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              valid,
  input  wire logic [31:0]       addr,
  input  wire logic              remap_ok,
  input  wire brad_pkg::brad_boot_t boot_src,
  output brad_pkg::brad_slave_t  slave,
  output logic [7:0]             cs_onehot,
  output logic [31:0]            slave_addr,
  output logic                   abort,
  output logic                   system_controller_hit
);
  typedef struct packed {
    brad_pkg::brad_slave_t slave;
    logic [7:0]            cs;
    logic [31:0]           addr;
    logic                  abort;
    logic                  system_controller;
  } brad_dec_t;

  brad_dec_t st_r;
  brad_dec_t st_nxt;

  function automatic brad_pkg::brad_slave_t int_slave(input logic [15:0] sub);
    if (sub >= brad_pkg::INT_ROM_BASE && sub <= brad_pkg::INT_ROM_LAST)
      return brad_pkg::BRAD_SL_ROM;
    else if (sub == brad_pkg::INT_SRAM0_BASE)
      return brad_pkg::BRAD_SL_SRAM0;
    else if (sub == brad_pkg::INT_SRAM1_BASE)
      return brad_pkg::BRAD_SL_SRAM1;
    else if (sub >= brad_pkg::INT_UHP_BASE && sub <= brad_pkg::INT_UHP_LAST)
      return brad_pkg::BRAD_SL_UHP;
    else
      return brad_pkg::BRAD_SL_NONE;
  endfunction : int_slave

  assign slave      = st_r.slave;
  assign cs_onehot  = st_r.cs;
  assign slave_addr = st_r.addr;
  assign abort      = st_r.abort;
  assign system_controller_hit   = st_r.system_controller;

  always_comb begin
    logic [3:0] bank;
    logic [3:0] csn;
    bank   = addr[brad_pkg::BANK_MSB:brad_pkg::BANK_LSB];
    csn    = 4'h0;
    st_nxt = '0;
    st_nxt.slave = brad_pkg::BRAD_SL_NONE;
    st_nxt.addr  = addr;
    if (valid) begin
      case (bank)
        brad_pkg::BANK_INTERNAL: begin
          if (addr[27:brad_pkg::INT_AREA_LSB] == 8'h00) begin
            case (remap_ok ? brad_pkg::BRAD_BOOT_SRAM : boot_src)
              brad_pkg::BRAD_BOOT_ROM:  st_nxt.slave = brad_pkg::BRAD_SL_ROM;
              brad_pkg::BRAD_BOOT_EXT: begin
                st_nxt.slave = brad_pkg::BRAD_SL_EBI;
                st_nxt.cs    = 8'h01;
              end
              brad_pkg::BRAD_BOOT_SRAM: st_nxt.slave = brad_pkg::BRAD_SL_SRAM0;
              default:                  st_nxt.slave = brad_pkg::BRAD_SL_NONE;
            endcase
          end else begin
            st_nxt.slave = int_slave(addr[27:12]);
          end
        end
        brad_pkg::BANK_PERIPH: begin
          st_nxt.slave = brad_pkg::BRAD_SL_APB;
          st_nxt.system_controller  = (addr >= brad_pkg::SYSTEM_CONTROLLER_WIN_BASE);
        end
        default: begin
          if (bank >= brad_pkg::BANK_EXT_FIRST && bank <= brad_pkg::BANK_EXT_LAST) begin
            csn          = bank - brad_pkg::BANK_EXT_FIRST;
            st_nxt.slave = brad_pkg::BRAD_SL_EBI;
            st_nxt.cs    = 8'h01 << csn[2:0];
            st_nxt.addr  = {6'h00, addr[brad_pkg::EXT_ADDR_W-1:0]};
          end
        end
      endcase
      st_nxt.abort = (st_nxt.slave == brad_pkg::BRAD_SL_NONE);
    end
    if (st_nxt.slave == brad_pkg::BRAD_SL_EBI && bank == brad_pkg::BANK_INTERNAL)
      st_nxt.addr = {6'h00, addr[brad_pkg::EXT_ADDR_W-1:0]};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r       <= '0;
      st_r.slave <= brad_pkg::BRAD_SL_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : brad_decode

/* logic/brad_matrix.sv */
`timescale 1ns/1ps
// Function
// - Split 4 GB into sixteen 256 MB banks on address bits 31..28.
// - Bank zero goes to internal memories with second-level decode on 4 KB pages (bits 27..12).
// - Banks 1 to 8 go to external bus, chip selects 0 to 7.
// - Each external chip select owns exactly one 256 MB bank.
// - Bank fifteen goes to peripherals through the APB bridge.
// - Unused regions, 0x90000000 to 0xEFFFFFFF included, return abort.
// - Every master has its own decoder, all with one map.
// - Processor masters see ROM, external boot or SRAM0 at address zero.
// - Area 0 to 0x000FFFFF reserved for boot memory; fetch starts at zero.
// - Boot pin high at reset, no remap: ROM at zero.
// - Boot pin low at reset, no remap: external chip select zero at zero.
// - Software remap puts SRAM0 at zero, regardless of boot pin.
// - Unaffected memories stay visible at their normal bases.
// - System controller windows decode in the top 16 KB.
// - External boot starts static controller byte-select, 16-bit, CS-controlled strobes.
// - System runs from slow clock at boot, RC or 32768 Hz.
// - Chip select one goes to SDRAM or static controller by configuration.
// - Chip select three optionally enables NAND flash logic.
// - External address bus carries up to 26 bits, 64 MB per select.
// - Boot select pin is sampled at reset to pick boot memory.
module brad_matrix #(
  parameter int NUM_MASTERS = 6
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        boot_select_pin,
  input  wire logic                        remap_set,
  input  wire logic                        remap_clear,
  input  wire logic                        cs1_sdram_sel,
  input  wire logic                        cs3_nand_en,
  input  wire logic [NUM_MASTERS-1:0]      m_valid,
  input  wire logic [NUM_MASTERS*32-1:0]   m_addr,
  output logic [NUM_MASTERS*3-1:0]         m_slave,
  output logic [NUM_MASTERS*8-1:0]         m_cs,
  output logic [NUM_MASTERS*32-1:0]        m_slave_addr,
  output logic [NUM_MASTERS-1:0]           m_abort,
  output logic [NUM_MASTERS-1:0]           m_system_controller_hit,
  output logic                             remap_active,
  output logic                             boot_from_rom,
  output logic                             slow_clock_boot,
  output logic                             smc_cs0_byte_select,
  output logic [4:0]                       smc_cs0_bus_width,
  output logic                             smc_cs0_rw_by_cs,
  output logic                             cs1_to_sdram,
  output logic                             cs3_nand_active
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic remap;
    logic slow_clk;
    logic cs1_sdram;
    logic cs3_nand;
  } brad_top_t;

  brad_top_t st_r;
  brad_top_t st_nxt;
  logic      rom_sel;
  brad_pkg::brad_boot_t boot_cpu;
  brad_pkg::brad_boot_t boot_dma;

  brad_strap u_strap (
    .clk             (clk),
    .srst            (srst),
    .boot_select_pin (boot_select_pin),
    .boot_rom_sel    (rom_sel)
  );

  always_comb begin
    st_nxt = st_r;
    if (remap_set)
      st_nxt.remap = 1'b1;
    else if (remap_clear)
      st_nxt.remap = 1'b0;
    st_nxt.cs1_sdram = cs1_sdram_sel;
    st_nxt.cs3_nand  = cs3_nand_en;
    // Slow clock held set every cycle; no input clears it
    st_nxt.slow_clk  = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.remap     <= brad_pkg::REMAP_RST;
      st_r.slow_clk  <= 1'b1;
      st_r.cs1_sdram <= 1'b0;
      st_r.cs3_nand  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Boot source at address zero
  // ****************************************************************
  // zero area selection
  always_comb begin
    if (st_r.remap)
      boot_cpu = brad_pkg::BRAD_BOOT_SRAM;
    else if (rom_sel)
      boot_cpu = brad_pkg::BRAD_BOOT_ROM;
    else
      boot_cpu = brad_pkg::BRAD_BOOT_EXT;
  end
  // Non-processor masters share the map; the zero alias follows the same choice
  assign boot_dma = boot_cpu;

  // ****************************************************************
  // Per-master decoders
  // ****************************************************************
  // one decoder per master
  for (genvar i = 0; i < NUM_MASTERS; i++) begin : g_dec
    brad_pkg::brad_slave_t sl;
    logic [7:0]            cs_raw;
    brad_decode u_dec (
      .clk        (clk),
      .srst       (srst),
      .valid      (m_valid[i]),
      .addr       (m_addr[i*32 +: 32]),
      .remap_ok   (st_r.remap),
      .boot_src   ((i < 2) ? boot_cpu : boot_dma),
      .slave      (sl),
      .cs_onehot  (cs_raw),
      .slave_addr (m_slave_addr[i*32 +: 32]),
      .abort      (m_abort[i]),
      .system_controller_hit   (m_system_controller_hit[i])
    );
    assign m_slave[i*3 +: 3] = sl;
    assign m_cs[i*8 +: 8]    = cs_raw;
  end

  // ****************************************************************
  // Status and external controller defaults
  // ****************************************************************
  assign remap_active        = st_r.remap;
  assign boot_from_rom       = rom_sel;
  assign slow_clock_boot     = st_r.slow_clk;
  assign smc_cs0_byte_select = 1'b1;
  assign smc_cs0_bus_width   = 5'(brad_pkg::BOOT_BUS_WIDTH);
  assign smc_cs0_rw_by_cs    = 1'b1;
  assign cs1_to_sdram        = st_r.cs1_sdram;
  assign cs3_nand_active     = st_r.cs3_nand;
endmodule : brad_matrix

/* logic/brad_pkg.sv */
package brad_pkg;
  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int          BANK_MSB          = 31;
  localparam int          BANK_LSB          = 28;
  localparam logic [3:0]  BANK_INTERNAL     = 4'h0;
  localparam logic [3:0]  BANK_EXT_FIRST    = 4'h1;
  localparam logic [3:0]  BANK_EXT_LAST     = 4'h8;
  localparam logic [3:0]  BANK_PERIPH       = 4'hF;
  // Boot area is the first Mbyte of bank zero: address bits 27..20 zero
  localparam int          INT_AREA_LSB      = 20;
  // Internal memories in bank zero, matched on address bits 27..12 (4K pages)
  localparam logic [15:0] INT_ROM_BASE      = 16'h0100;
  localparam logic [15:0] INT_ROM_LAST      = 16'h0107;
  localparam logic [15:0] INT_SRAM0_BASE    = 16'h0200;
  localparam logic [15:0] INT_SRAM1_BASE    = 16'h0300;
  localparam logic [15:0] INT_UHP_BASE      = 16'h0500;
  localparam logic [15:0] INT_UHP_LAST      = 16'h0503;
  // System controller window: top 16 Kbytes, registers from 0xFFFFE800
  localparam logic [31:0] SYSTEM_CONTROLLER_WIN_BASE     = 32'hFFFFC000;
  localparam logic [31:0] SYSTEM_CONTROLLER_REG_BASE     = 32'hFFFFE800;
  // External bus
  localparam int          EXT_ADDR_W        = 26;
  localparam int          NUM_CS            = 8;
  localparam int          BOOT_BUS_WIDTH    = 16;
  // Values after reset
  localparam logic        REMAP_RST         = 1'b0;
  localparam logic        BOOT_SEL_RST      = 1'b1;

  typedef enum logic [2:0] {
    BRAD_SL_NONE,
    BRAD_SL_ROM,
    BRAD_SL_SRAM0,
    BRAD_SL_SRAM1,
    BRAD_SL_UHP,
    BRAD_SL_EBI,
    BRAD_SL_APB
  } brad_slave_t;

  typedef enum logic [1:0] {
    BRAD_BOOT_ROM,
    BRAD_BOOT_EXT,
    BRAD_BOOT_SRAM
  } brad_boot_t;
endpackage : brad_pkg

/* logic/brad_strap.sv */
`timescale 1ns/1ps
// Samples the boot select pin through two flops and latches it at reset release
module brad_strap (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic boot_select_pin,
  output logic      boot_rom_sel
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic held;
    logic armed;
  } brad_strap_t;

  brad_strap_t st_r;
  brad_strap_t st_nxt;

  assign boot_rom_sel = st_r.held;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = boot_select_pin;
    st_nxt.sync = st_r.meta;
    if (srst) begin
      st_nxt.armed = 1'b1;
      st_nxt.held  = brad_pkg::BOOT_SEL_RST;
    end else if (st_r.armed) begin
      // Capture at the first edge after release; pin ignored afterwards
      st_nxt.held  = st_r.sync;
      st_nxt.armed = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
endmodule : brad_strap

/* tb/brad_mstr.sv */
`timescale 1ns/1ps
// ************************************************
// Bus masters and boot software
// ************************************************
module brad_mstr #(
  parameter int N = 6
) (
  input  wire logic  clk,
  output logic [N-1:0]    m_valid,
  output logic [N*32-1:0] m_addr,
  output logic       remap_set,
  output logic       remap_clear
);
  initial begin
    m_valid = '0;
    m_addr = '0;
    remap_set = 1'b0;
    remap_clear = 1'b0;
  end
  // With all masters idle the address is inverted so stale values are never decoded
  task automatic put(input logic [N-1:0] v, input logic [31:0] a);
    @(negedge clk);
    m_valid = v;
    m_addr = (v != '0) ? {N{a}} : ~m_addr;
  endtask : put
  task automatic remap(input logic on);
    @(negedge clk);
    remap_set = on;
    remap_clear = !on;
    @(negedge clk);
    remap_set = 1'b0;
    remap_clear = 1'b0;
  endtask : remap
endmodule : brad_mstr

/* tb/brad_props.sv */
`timescale 1ns/1ps
module brad_props #(
  parameter int NUM_MASTERS = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic remap_set,
  input wire logic remap_clear,
  input wire logic [NUM_MASTERS-1:0]    m_valid,
  input wire logic [NUM_MASTERS*32-1:0] m_addr,
  input wire logic [NUM_MASTERS*3-1:0]  m_slave,
  input wire logic [NUM_MASTERS*8-1:0]  m_cs,
  input wire logic [NUM_MASTERS-1:0]    m_abort,
  input wire logic remap_active,
  input wire logic boot_from_rom
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ext_bank_a: assert property (
    m_valid[0] && m_addr[31:28] inside {[4'h1:4'h8]} |=> m_slave[2:0] == 3'h5
    && m_cs[7:0] == 8'h01 << ($past(m_addr[31:28]) - 4'h1)) else $error("bad chip select");
  periph_bank_a: assert property (
    m_valid[0] && m_addr[31:28] == 4'hF |=> m_slave[2:0] == 3'h6 && !m_abort[0]) else $error("bad periph");
  hole_abort_a: assert property (
    m_valid[0] && m_addr[31:28] inside {[4'h9:4'hE]} |=> m_abort[0] && m_cs[7:0] == 8'h00) else $error("no abort");
  one_select_a: assert property (
    $onehot0(m_cs[7:0]) && (!m_abort[0] || m_slave[2:0] == 3'h0)) else $error("select clash");
  rom_alias_a: assert property (
    m_valid[0] && m_addr[31:12] == 20'h0 && !remap_active && boot_from_rom && !$past(srst)
    |=> m_slave[2:0] == 3'h1) else $error("no rom alias");
  ext_alias_a: assert property (
    m_valid[0] && m_addr[31:12] == 20'h0 && !remap_active && !boot_from_rom && !$past(srst)
    |=> m_slave[2:0] == 3'h5 && m_cs[7:0] == 8'h01) else $error("no ext alias");
  sram_alias_a: assert property (
    m_valid[1] && m_addr[63:44] == 20'h0 && remap_active |=> m_slave[5:3] == 3'h2) else $error("no remap");
  remap_cmd_a: assert property (
    (remap_set |=> remap_active) and (remap_clear && !remap_set |=> !remap_active)) else $error("remap ctl");
  reset_clear_a: assert property (disable iff (1'b0)
    srst |=> !remap_active && m_abort == '0) else $error("reset state");
  cover property (m_abort[0]);
  cover property (remap_active && m_slave[2:0] == 3'h2);
  cover property (!boot_from_rom && m_cs[0]);
endmodule : brad_props
bind brad_matrix brad_props #(.NUM_MASTERS(NUM_MASTERS)) brad_props_inst (.clk(clk), .srst(srst),
  .remap_set(remap_set), .remap_clear(remap_clear), .m_valid(m_valid), .m_addr(m_addr), .m_slave(m_slave),
  .m_cs(m_cs), .m_abort(m_abort), .remap_active(remap_active), .boot_from_rom(boot_from_rom));

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam int N = 6;
  localparam logic [2:0] NONE = brad_pkg::BRAD_SL_NONE, ROM = brad_pkg::BRAD_SL_ROM;
  localparam logic [2:0] SR0 = brad_pkg::BRAD_SL_SRAM0, EXTERNAL_BUS_INTERFACE = brad_pkg::BRAD_SL_EBI;
  logic [N-1:0]    m_valid, m_abort, m_system_controller_hit;
  logic [N*32-1:0] m_addr, m_slave_addr;
  logic [N*3-1:0]  m_slave;
  logic [N*8-1:0]  m_cs;
  logic [4:0]      bw;
  logic            clk, srst, pin, cs1s, cs3n, rs, rc, ra, bfr, scb, bs, rwc, sdr, nand_on;
  int              n_mismatch = 0, n_compared = 0, cyc = 0;
  brad_matrix #(.NUM_MASTERS(N)) brad_matrix_inst (.clk(clk), .srst(srst), .boot_select_pin(pin),
    .remap_set(rs), .remap_clear(rc), .cs1_sdram_sel(cs1s), .cs3_nand_en(cs3n), .m_valid(m_valid),
    .m_addr(m_addr), .m_slave(m_slave), .m_cs(m_cs), .m_slave_addr(m_slave_addr), .m_abort(m_abort),
    .m_system_controller_hit(m_system_controller_hit), .remap_active(ra), .boot_from_rom(bfr), .slow_clock_boot(scb),
    .smc_cs0_byte_select(bs), .smc_cs0_bus_width(bw), .smc_cs0_rw_by_cs(rwc), .cs1_to_sdram(sdr),
    .cs3_nand_active(nand_on));
  brad_mstr #(.N(N)) brad_mstr_inst (.clk(clk), .m_valid(m_valid), .m_addr(m_addr), .remap_set(rs),
    .remap_clear(rc));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Pin is held through the whole reset so it is stable around release
  task automatic do_reset(input logic p);
    srst = 1'b1;
    pin = p;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset
  // All masters request the same address in one cycle and must agree
  task automatic dec(input logic [31:0] a, input logic [2:0] sl, input logic [7:0] cs, input logic ab);
    brad_mstr_inst.put('1, a);
    @(negedge clk);
    for (int i = 0; i < N; i++) begin
      chk(32'(m_slave[i*3+:3]), 32'(sl));
      chk({m_cs[i*8+:8], 23'h0, m_abort[i]}, {cs, 23'h0, ab});
      chk(32'(m_system_controller_hit[i]), 32'(a >= 32'hFFFFC000));
      if (!ab) chk(m_slave_addr[i*32+:32], (sl == EXTERNAL_BUS_INTERFACE) ? {6'h0, a[25:0]} : a);
    end
  endtask : dec
  task automatic t_boot();
    do_reset(1'b0);
    chk(32'(bfr), 32'h0);
    chk(32'({scb, bs, bw, rwc}), 32'({1'b1, 1'b1, 5'h10, 1'b1}));
    chk(32'(scb), 32'h1);
    dec(32'h00000010, EXTERNAL_BUS_INTERFACE, 8'h01, 1'b0);
    dec(32'h00100000, ROM, 8'h00, 1'b0);
    brad_mstr_inst.remap(1'b1);
    dec(32'h00000010, SR0, 8'h00, 1'b0);
    do_reset(1'b1);
    chk({31'h0, ra}, 32'h0);
    dec(32'h00000000, ROM, 8'h00, 1'b0);
    dec(32'h000FFFFC, ROM, 8'h00, 1'b0);
    dec(32'h00200004, SR0, 8'h00, 1'b0);
    brad_mstr_inst.remap(1'b1);
    dec(32'h00000FFC, SR0, 8'h00, 1'b0);
    brad_mstr_inst.remap(1'b0);
    dec(32'h00000004, ROM, 8'h00, 1'b0);
  endtask : t_boot
  task automatic t_map();
    for (int b = 1; b <= 8; b++) dec({b[3:0], 28'hFFFFFFC}, EXTERNAL_BUS_INTERFACE, 8'h01 << (b - 1), 1'b0);
    dec(32'h90000000, NONE, 8'h00, 1'b1);
    dec(32'hEFFFFFFF, NONE, 8'h00, 1'b1);
    dec(32'hF0000000, brad_pkg::BRAD_SL_APB, 8'h00, 1'b0);
    dec(32'hFFFFE800, brad_pkg::BRAD_SL_APB, 8'h00, 1'b0);
    dec(32'h00300008, brad_pkg::BRAD_SL_SRAM1, 8'h00, 1'b0);
    dec(32'h00500010, brad_pkg::BRAD_SL_UHP, 8'h00, 1'b0);
    dec(32'h00400000, NONE, 8'h00, 1'b1);
    dec(32'h01000000, NONE, 8'h00, 1'b1);
    brad_mstr_inst.put('0, 32'h0);
    @(negedge clk);
    chk(32'(m_abort), 32'h0);
  endtask : t_map
  task automatic t_cfg();
    cs1s = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({sdr, nand_on}), 32'h2);
    cs1s = 1'b0;
    cs3n = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({sdr, nand_on}), 32'h1);
  endtask : t_cfg
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    pin = 1'b1;
    cs1s = 1'b0;
    cs3n = 1'b0;
    t_boot();
    t_map();
    t_cfg();
    final_report();
  end
endmodule : tb
